//--- core/rx_flow_defs.svh
// register offsets, field positions, reset values and timing figures
// for the receive flow control and indirect mac register bridge.
// assumes inclusion by bare name from the design file only.
`ifndef RX_FLOW_DEFS_SVH
`define RX_FLOW_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets on the host register port
// ----------------------------------------------------------------
`define OFS_MAC_INDIRECT_COMMAND 8'ha4
`define OFS_MAC_INDIRECT_DATA 8'ha8
`define OFS_AUTO_FLOW_CONFIG 8'hac

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_BUSY_BIT 31
`define CMD_RNW_BIT 30
`define CMD_ADDR_MSB 7
`define AFC_HIGH_MSB 23
`define AFC_HIGH_LSB 16
`define AFC_LOW_MSB 15
`define AFC_LOW_LSB 8
`define AFC_BP_MSB 7
`define AFC_BP_LSB 4
`define AFC_MULTICAST_BIT 3
`define AFC_BROADCAST_BIT 2
`define AFC_OWN_ADDR_BIT 1
`define AFC_ANY_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MAC_CMD_RESET 32'h00000000
`define MAC_DATA_RESET 32'h00000000
`define AUTO_FLOW_CONFIG_RESET 32'h00000000

// ----------------------------------------------------------------
// thresholds count in 64 byte units, i.e. a shift of 6
// ----------------------------------------------------------------
`define LEVEL_UNIT_SHIFT 6

// ----------------------------------------------------------------
// timing: clock rate and jam durations in microseconds / ns
// ----------------------------------------------------------------
`define CLK_MHZ 25
`define BP_US_CODE0 10'd5
`define BP_US_CODE1 10'd10
`define BP_US_CODE2 10'd15
`define BP_US_CODE3 10'd25
`define BP_STEP_US 10'd50
`define BP_10M_EXTRA_NS 2200

`endif

//--- core/rx_flow_pkg.sv
// types shared by the flow control and register bridge design.
// assumes nothing of its surroundings.
package rx_flow_pkg;

    // flow control episode: idle, or pause sent and release armed
    typedef enum logic [0:0] {
        FLOW_IDLE = 1'b0,
        FLOW_PAUSED = 1'b1
    } flow_state_t;

    // indirect access sequencer
    typedef enum logic [0:0] {
        BRIDGE_IDLE = 1'b0,
        BRIDGE_WAIT = 1'b1
    } bridge_state_t;

endpackage

//--- core/rx_flow_control_csr_bridge.sv
// automatic receive flow control (pause frames / back pressure) and
// the indirect command/data path to the mac control registers.
// assumes one 25 mhz clock, synchronous inputs, and a mac register
// port that answers each request with a one-cycle ack.
`timescale 1ns/1ps
`include "rx_flow_defs.svh"

module rx_flow_control_csr_bridge #(
    parameter int FIFO_W = 14,
    parameter int BP_CYCLES_PER_US = `CLK_MHZ
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // host register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    // mac control register port
    output logic mac_req_out,
    output logic mac_read_out,
    output logic [7:0] mac_addr_out,
    output logic [31:0] mac_wdata_out,
    input wire logic mac_ack_in,
    input wire logic [31:0] mac_rdata_in,
    // receive side status
    input wire logic tx_enable_in,
    input wire logic full_duplex_in,
    input wire logic speed_100_in,
    input wire logic [FIFO_W-1:0] rx_fifo_level_in,
    input wire logic rx_preamble_in,
    input wire logic rx_addr_done_in,
    input wire logic rx_multicast_in,
    input wire logic rx_broadcast_in,
    input wire logic rx_own_addr_in,
    input wire logic [15:0] pause_time_value_in,
    // transmit side requests
    output logic pause_req_out,
    output logic [15:0] pause_time_out,
    input wire logic pause_done_in,
    output logic jam_out
);
    import rx_flow_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic busy_q;
    logic rnw_q;
    logic [7:0] addr_q;
    logic [31:0] data_q;
    logic [31:0] afc_q;
    logic [31:0] reg_rdata_q;
    bridge_state_t bridge_q;
    flow_state_t flow_q;
    logic pause_req_q;
    logic release_q;
    logic [15:0] pause_time_q;
    logic [15:0] jam_cnt_q;

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    logic [7:0] flow_trigger_high_level;
    logic [7:0] flow_release_low_level;
    logic [3:0] backpressure_length;
    logic multicast_jam_enable;
    logic broadcast_jam_enable;
    logic own_address_jam_enable;
    logic any_frame_flow_enable;
    logic flow_enabled;
    logic [FIFO_W-1:0] high_thr;
    logic [FIFO_W-1:0] low_thr;
    logic high_hit;
    logic below_low;
    logic frame_match;
    logic jam_start;
    logic pause_start;
    logic release_start;
    logic [15:0] bp_cycles;

    assign flow_trigger_high_level = afc_q[`AFC_HIGH_MSB:`AFC_HIGH_LSB];
    assign flow_release_low_level = afc_q[`AFC_LOW_MSB:`AFC_LOW_LSB];
    assign backpressure_length = afc_q[`AFC_BP_MSB:`AFC_BP_LSB];
    assign multicast_jam_enable = afc_q[`AFC_MULTICAST_BIT];
    assign broadcast_jam_enable = afc_q[`AFC_BROADCAST_BIT];
    assign own_address_jam_enable = afc_q[`AFC_OWN_ADDR_BIT];
    assign any_frame_flow_enable = afc_q[`AFC_ANY_BIT];
    assign flow_enabled = |afc_q[`AFC_MULTICAST_BIT:`AFC_ANY_BIT];

    // thresholds scaled to bytes; widths above 14 bits just zero-extend
    assign high_thr = FIFO_W'({flow_trigger_high_level, 6'h00});
    assign low_thr = FIFO_W'({flow_release_low_level, 6'h00});
    assign high_hit = rx_fifo_level_in >= high_thr;
    assign below_low = rx_fifo_level_in < low_thr;

    // ----------------------------------------------------------------
    // jam duration lookup
    // ----------------------------------------------------------------
    // codes 4..f step by 50 us from 50 us; the first four are irregular
    function automatic logic [9:0] bp_us(input logic [3:0] code);
        logic [9:0] r;
        r = 10'h000;
        case (code)
            4'h0: r = `BP_US_CODE0;
            4'h1: r = `BP_US_CODE1;
            4'h2: r = `BP_US_CODE2;
            4'h3: r = `BP_US_CODE3;
            default: r = 10'(({6'h00, code} - 10'h003) * `BP_STEP_US);
        endcase
        return r;
    endfunction

    // 10 mb/s adds a fixed 2.2 us on top of the 100 mb/s figure
    localparam int BP_10M_EXTRA_CYC = (`BP_10M_EXTRA_NS * `CLK_MHZ) / 1000;
    assign bp_cycles = 16'(32'(bp_us(backpressure_length)) * BP_CYCLES_PER_US) +
        (speed_100_in ? 16'h0000 : 16'(BP_10M_EXTRA_CYC));

    // ----------------------------------------------------------------
    // host register writes
    // ----------------------------------------------------------------
    logic cmd_wr;
    logic data_wr;
    logic launch;
    assign cmd_wr = reg_wr_in && (reg_addr_in == `OFS_MAC_INDIRECT_COMMAND);
    assign data_wr = reg_wr_in && (reg_addr_in == `OFS_MAC_INDIRECT_DATA);
    assign launch = cmd_wr && !busy_q && reg_wdata_in[`CMD_BUSY_BIT];

    // command fields are frozen while busy so a stray write cannot
    // redirect an access already in flight
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rnw_q <= 1'(`MAC_CMD_RESET >> `CMD_RNW_BIT);
            addr_q <= 8'h00;
        end else if (cmd_wr && !busy_q) begin
            rnw_q <= reg_wdata_in[`CMD_RNW_BIT];
            addr_q <= reg_wdata_in[`CMD_ADDR_MSB:0];
        end
    end

    // flow configuration; reserved bits 31:24 stay zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            afc_q <= `AUTO_FLOW_CONFIG_RESET;
        end else if (reg_wr_in && (reg_addr_in == `OFS_AUTO_FLOW_CONFIG)) begin
            afc_q <= {8'h00, reg_wdata_in[`AFC_HIGH_MSB:0]};
        end
    end

    // ----------------------------------------------------------------
    // indirect access sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bridge_q <= BRIDGE_IDLE;
            busy_q <= 1'b0;
        end else begin
            case (bridge_q)
                BRIDGE_IDLE: begin
                    if (launch) begin
                        bridge_q <= BRIDGE_WAIT;
                        busy_q <= 1'b1;
                    end
                end
                BRIDGE_WAIT: begin
                    if (mac_ack_in) begin
                        bridge_q <= BRIDGE_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    bridge_q <= BRIDGE_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // data register: host writes when idle, read results on ack
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            data_q <= `MAC_DATA_RESET;
        end else if (bridge_q == BRIDGE_WAIT && mac_ack_in && rnw_q) begin
            data_q <= mac_rdata_in;
        end else if (data_wr && !busy_q) begin
            data_q <= reg_wdata_in;
        end
    end

    // request held level-wise until the mac side acknowledges
    assign mac_req_out = (bridge_q == BRIDGE_WAIT);
    assign mac_read_out = rnw_q;
    assign mac_addr_out = addr_q;
    assign mac_wdata_out = data_q;

    // ----------------------------------------------------------------
    // host register reads, one cycle latency
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `OFS_MAC_INDIRECT_COMMAND: reg_rdata_q <= {busy_q, rnw_q, 22'h000000, addr_q};
                `OFS_MAC_INDIRECT_DATA: reg_rdata_q <= data_q;
                `OFS_AUTO_FLOW_CONFIG: reg_rdata_q <= afc_q;
                default: reg_rdata_q <= 32'h00000000;
            endcase
        end
    end
    assign reg_rdata_out = reg_rdata_q;

    // ----------------------------------------------------------------
    // half duplex back pressure
    // ----------------------------------------------------------------
    // any-frame jams at the preamble; the others wait for address decode
    assign frame_match = any_frame_flow_enable ? rx_preamble_in :
        (rx_addr_done_in && ((multicast_jam_enable && rx_multicast_in) ||
        (broadcast_jam_enable && rx_broadcast_in) ||
        (own_address_jam_enable && rx_own_addr_in)));
    assign jam_start = tx_enable_in && !full_duplex_in && high_hit &&
        frame_match && (jam_cnt_q == 16'h0000);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            jam_cnt_q <= 16'h0000;
        end else if (!tx_enable_in || full_duplex_in) begin
            jam_cnt_q <= 16'h0000;
        end else if (jam_start) begin
            jam_cnt_q <= bp_cycles;
        end else if (jam_cnt_q != 16'h0000) begin
            jam_cnt_q <= jam_cnt_q - 16'h0001;
        end
    end
    assign jam_out = (jam_cnt_q != 16'h0000) && tx_enable_in;

    // ----------------------------------------------------------------
    // full duplex pause generation
    // ----------------------------------------------------------------
    // one pause per episode: only the idle state may start one
    assign pause_start = tx_enable_in && full_duplex_in && any_frame_flow_enable &&
        (flow_q == FLOW_IDLE) && high_hit && rx_preamble_in && !pause_req_q;
    assign release_start = tx_enable_in && flow_enabled &&
        (flow_q == FLOW_PAUSED) && below_low && !pause_req_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flow_q <= FLOW_IDLE;
        end else begin
            case (flow_q)
                FLOW_IDLE: begin
                    if (pause_start) begin
                        flow_q <= FLOW_PAUSED;
                    end
                end
                FLOW_PAUSED: begin
                    // disabling every criterion abandons the episode silently
                    if (release_start || !flow_enabled) begin
                        flow_q <= FLOW_IDLE;
                    end
                end
                default: flow_q <= FLOW_IDLE;
            endcase
        end
    end

    // request stands until the transmitter reports the frame done;
    // a pending request is withdrawn if the transmitter is switched off
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pause_req_q <= 1'b0;
        end else if (!tx_enable_in) begin
            pause_req_q <= 1'b0;
        end else if (pause_start || release_start) begin
            pause_req_q <= 1'b1;
        end else if (pause_done_in) begin
            pause_req_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pause_time_q <= 16'h0000;
            release_q <= 1'b0;
        end else if (pause_start) begin
            pause_time_q <= pause_time_value_in;
            release_q <= 1'b0;
        end else if (release_start) begin
            pause_time_q <= 16'h0000;
            release_q <= 1'b1;
        end
    end
    assign pause_req_out = pause_req_q;
    assign pause_time_out = pause_time_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_tx_off_quiet: assert property (!tx_enable_in |=> !pause_req_out && !jam_out)
        else $error("flow control active with transmitter disabled");
    a_pause_once: assert property ($rose(pause_req_out) && !release_q |-> $past(flow_q) == FLOW_IDLE)
        else $error("second pause frame in one episode");
    a_pause_time_src: assert property ($rose(pause_req_out) && !release_q |->
        pause_time_out == $past(pause_time_value_in) && $past(high_hit))
        else $error("pause frame time or trigger wrong");
    a_release_zero: assert property ($rose(pause_req_out) && release_q |->
        pause_time_out == 16'h0000 && $past(below_low) && $past(flow_q) == FLOW_PAUSED)
        else $error("release frame without armed episode or nonzero time");
    a_jam_length: assert property (jam_start |=> jam_cnt_q == $past(bp_cycles))
        else $error("jam length not loaded from duration code");
    a_jam_cause: assert property ($rose(jam_out) |-> $past(high_hit) && !$past(full_duplex_in))
        else $error("jam started without threshold in half duplex");
    a_busy_launch: assert property (launch |=> busy_q && mac_req_out && mac_addr_out == $past(reg_wdata_in[7:0]))
        else $error("busy or request missing after launch");
    a_busy_hold: assert property (busy_q && !mac_ack_in |=> busy_q)
        else $error("busy cleared before completion");
    a_read_data: assert property (busy_q && mac_ack_in && rnw_q |=> !busy_q && data_q == $past(mac_rdata_in))
        else $error("read data not valid when busy clears");

endmodule

//--- tb/rx_flow_far_side.sv
// far side model: the mac control register file and the transmitter that
// sends pause frames. assumes the bridge's req/ack and pause req/done forms.
`timescale 1ns/1ps

module rx_flow_far_side (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] ack_wait_in,
    input wire logic mac_req_in,
    input wire logic mac_read_in,
    input wire logic [7:0] mac_addr_in,
    input wire logic [31:0] mac_wdata_in,
    output logic mac_ack_out,
    output logic [31:0] mac_rdata_out,
    input wire logic pause_req_in,
    output logic pause_done_out
);
    logic [31:0] mem_q [0:255];
    logic [3:0] wait_q;
    logic [1:0] tx_q;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // read data is scrambled outside the ack cycle so a stale value never
    // passes for a fresh one; ack_wait_in makes the answer prompt or slow
    always_ff @(posedge clk_in) begin
        mac_ack_out <= 1'b0;
        mac_rdata_out <= ~mac_rdata_out;
        if (rst_in) begin
            wait_q <= 4'h0;
            mac_rdata_out <= 32'h5a5a0f0f;
        end else if (mac_req_in && !mac_ack_out) begin
            if (wait_q >= ack_wait_in) begin
                wait_q <= 4'h0;
                mac_ack_out <= 1'b1;
                if (mac_read_in) begin
                    mac_rdata_out <= mem_q[mac_addr_in];
                end else begin
                    mem_q[mac_addr_in] <= mac_wdata_in;
                end
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    // a pause frame takes three cycles on the wire, then done pulses once
    always_ff @(posedge clk_in) begin
        pause_done_out <= 1'b0;
        if (rst_in || !pause_req_in || pause_done_out) begin
            tx_q <= 2'h0;
        end else if (tx_q == 2'h2) begin
            pause_done_out <= 1'b1;
        end else begin
            tx_q <= tx_q + 2'h1;
        end
    end
endmodule

//--- tb/rx_flow_control_csr_bridge_tb_top.sv
// self-checking bench for the flow control and indirect register bridge.
// assumes the far side model; jam length scaled with one cycle per us.
`timescale 1ns/1ps

module rx_flow_control_csr_bridge_tb_top;
    localparam int BPC = 1;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out;
    logic mac_req, mac_read, mac_ack, preq, pdone, jam;
    logic [7:0] mac_addr;
    logic [31:0] mac_wdata, mac_rdata;
    logic [15:0] ptime;
    logic [15:0] ptv = 16'h0;
    logic [15:0] last_time = 16'h0;
    logic [13:0] level = 14'd0;
    logic [3:0] ack_wait = 4'h0;
    logic tx_en = 1'b0;
    logic fd = 1'b0;
    logic spd = 1'b1;
    logic pre = 1'b0;
    logic adone = 1'b0;
    logic mc = 1'b0;
    logic bc = 1'b0;
    logic own = 1'b0;
    logic preq_d = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    int n_pause = 0;
    int n_jam = 0;

    always #20 clk_in = ~clk_in;

    rx_flow_control_csr_bridge #(.FIFO_W(14), .BP_CYCLES_PER_US(BPC)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .mac_req_out(mac_req), .mac_read_out(mac_read), .mac_addr_out(mac_addr),
        .mac_wdata_out(mac_wdata), .mac_ack_in(mac_ack), .mac_rdata_in(mac_rdata),
        .tx_enable_in(tx_en), .full_duplex_in(fd), .speed_100_in(spd), .rx_fifo_level_in(level),
        .rx_preamble_in(pre), .rx_addr_done_in(adone), .rx_multicast_in(mc), .rx_broadcast_in(bc),
        .rx_own_addr_in(own), .pause_time_value_in(ptv), .pause_req_out(preq),
        .pause_time_out(ptime), .pause_done_in(pdone), .jam_out(jam));

    rx_flow_far_side far (
        .clk_in(clk_in), .rst_in(rst_in), .ack_wait_in(ack_wait), .mac_req_in(mac_req),
        .mac_read_in(mac_read), .mac_addr_in(mac_addr), .mac_wdata_in(mac_wdata),
        .mac_ack_out(mac_ack), .mac_rdata_out(mac_rdata), .pause_req_in(preq),
        .pause_done_out(pdone));

    // ------------------------------------------------------------
    // monitors and shared tasks
    // ------------------------------------------------------------
    // a pause frame is counted once at the rise of its request
    always @(posedge clk_in) begin
        preq_d <= preq;
        if (preq === 1'b1 && preq_d !== 1'b1) begin
            n_pause++;
            last_time = ptime;
        end
        if (jam === 1'b1) n_jam++;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
    endtask

    // the host keeps off both registers until busy reads clear
    task automatic wait_idle();
        logic [31:0] v;
        for (int i = 0; i < 40; i++) begin
            reg_read(8'ha4, v);
            if (v[31] === 1'b0) return;
        end
        check("busy clear", 32'h0, v);
    endtask

    // one received frame: preamble and address decode with its type flags
    task automatic frame(input logic [2:0] t);
        @(negedge clk_in);
        pre = 1'b1;
        adone = 1'b1;
        {mc, bc, own} = t;
        @(negedge clk_in);
        pre = 1'b0;
        adone = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] v;
        reg_read(8'ha4, v);
        check("cmd reset", 32'h0, v);
        reg_read(8'ha8, v);
        check("data reset", 32'h0, v);
        reg_read(8'hac, v);
        check("cfg reset", 32'h0, v);
        reg_read(8'ha0, v);
        check("unmapped read", 32'h0, v);
        reg_write(8'hac, 32'hffffffff);
        reg_read(8'hac, v);
        check("cfg fields", 32'h00ffffff, v);
        reg_write(8'ha4, 32'h7fffff12);
        reg_read(8'ha4, v);
        check("cmd fields", 32'h40000012, v);
        reg_write(8'hac, 32'h0);
    endtask

    task automatic t_indirect();
        logic [31:0] v;
        ack_wait = 4'h6;
        reg_write(8'ha8, 32'hcafe0001);
        reg_write(8'ha4, 32'h80000012);
        reg_read(8'ha4, v);
        check("busy during access", 32'h80000012, v);
        check("mac address", 32'h12, {24'h0, mac_addr});
        check("mac write data", 32'hcafe0001, mac_wdata);
        wait_idle();
        check("mac reg written", 32'hcafe0001, far.mem_q[8'h12]);
        reg_write(8'ha8, 32'h5a5aa5a5);
        reg_write(8'ha4, 32'h80000034);
        wait_idle();
        // clear the data register so only a real read can restore the value
        reg_write(8'ha8, 32'h00000000);
        reg_write(8'ha4, 32'hc0000034);
        check("mac read select", 32'h1, {31'h0, mac_read});
        wait_idle();
        reg_read(8'ha8, v);
        check("slow read data", 32'h5a5aa5a5, v);
        ack_wait = 4'h0;
        reg_write(8'ha4, 32'hc0000012);
        wait_idle();
        reg_read(8'ha8, v);
        check("fast read data", 32'hcafe0001, v);
    endtask

    task automatic t_full_duplex();
        int b = n_pause;
        tx_en = 1'b1;
        fd = 1'b1;
        ptv = 16'h1234;
        reg_write(8'hac, 32'h00020101);
        frame(3'b000);
        repeat (8) @(negedge clk_in);
        check("release unarmed", b, n_pause);
        level = 14'd127;
        frame(3'b000);
        repeat (8) @(negedge clk_in);
        check("below high level", b, n_pause);
        level = 14'd128;
        frame(3'b000);
        repeat (8) @(negedge clk_in);
        check("pause sent", b + 1, n_pause);
        check("pause time", 32'h1234, {16'h0, last_time});
        frame(3'b000);
        frame(3'b000);
        repeat (8) @(negedge clk_in);
        check("single pause", b + 1, n_pause);
        reg_write(8'hac, 32'h00020108);
        level = 14'd64;
        repeat (8) @(negedge clk_in);
        check("at low level", b + 1, n_pause);
        level = 14'd63;
        repeat (8) @(negedge clk_in);
        check("release sent", b + 2, n_pause);
        check("release time", 32'h0, {16'h0, last_time});
    endtask

    task automatic t_tx_off();
        int b = n_pause;
        int j = n_jam;
        tx_en = 1'b0;
        level = 14'd200;
        reg_write(8'hac, 32'h00020101);
        frame(3'b000);
        repeat (8) @(negedge clk_in);
        check("no pause tx off", b, n_pause);
        fd = 1'b0;
        frame(3'b000);
        repeat (12) @(negedge clk_in);
        check("no jam tx off", j, n_jam);
        tx_en = 1'b1;
    endtask

    task automatic t_half_duplex();
        logic [3:0] en [6] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h2, 4'h1};
        logic [2:0] ty [6] = '{3'b010, 3'b100, 3'b010, 3'b001, 3'b100, 3'b000};
        int ex [6] = '{0, 5, 5, 5, 0, 5};
        int j;
        for (int i = 0; i < 6; i++) begin
            reg_write(8'hac, {16'h0002, 8'h01, 4'h0, en[i]});
            j = n_jam;
            frame(ty[i]);
            repeat (5 * BPC + 8) @(negedge clk_in);
            check("jam cycles", ex[i] * BPC, n_jam - j);
        end
        spd = 1'b0;
        reg_write(8'hac, 32'h00020111);
        j = n_jam;
        frame(3'b000);
        repeat (10 * BPC + 70) @(negedge clk_in);
        check("jam at 10M code 1", 10 * BPC + 55, n_jam - j);
        fd = 1'b1;
        reg_write(8'hac, 32'h00020118);
        j = n_jam;
        frame(3'b100);
        repeat (12) @(negedge clk_in);
        check("no jam full duplex", 0, n_jam - j);
    endtask

    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        t_regs();
        t_indirect();
        t_full_duplex();
        t_tx_off();
        t_half_duplex();
        print_verdict();
    end
endmodule
